// File: src/axgc_pkg.sv
// Constants shared by the aux converter and output gain control block
package axgc_pkg;
	// Register indices carried in the link command address slot
	localparam logic [6:0]  HP_VOL_ADDR   = 7'h04;
	localparam logic [6:0]  AUX_OUT_ADDR  = 7'h12;
	localparam logic [6:0]  EAR_CTRL_ADDR = 7'h16;
	localparam logic [6:0]  AUX_IN_ADDR   = 7'h64;
	// Values after reset
	localparam logic [15:0] HP_VOL_RST    = 16'h8000;
	localparam logic [15:0] AUX_OUT_RST   = 16'haaa0;
	localparam logic [15:0] EAR_RST       = 16'h8000;
	localparam logic [15:0] AUX_IN_RST    = 16'h0000;
	// Implemented bits; the rest read as zero
	localparam logic [15:0] HP_VOL_MASK   = 16'hbfbf;
	localparam logic [15:0] AUX_OUT_MASK  = 16'hfff1;
	localparam logic [15:0] EAR_MASK      = 16'h86bf;
	localparam logic [15:0] AUX_IN_MASK   = 16'hffff;
	// Field positions
	localparam int MUTE_BIT     = 15;
	localparam int ZC_BIT       = 7;
	localparam int SRCSEL_BIT   = 15;
	localparam int SLOT_LSB     = 12;
	localparam int DC_LSB       = 0;
	localparam int SPK_MUTE_BIT = 11;
	localparam int PH_MUTE_BIT  = 7;
	localparam int ENABLE_BIT   = 0;
	localparam int HPG_LSB      = 12;
	localparam int SPKG_LSB     = 8;
	localparam int PHG_LSB      = 4;
	localparam int LVOL_LSB     = 8;
	localparam int RVOL_LSB     = 0;
	localparam int EARSRC_LSB   = 9;
	// Link framing
	localparam logic [3:0]  CMD_ADDR_SLOT  = 4'h1;
	localparam logic [3:0]  CMD_DATA_SLOT  = 4'h2;
	localparam logic [3:0]  FIRST_AUX_SLOT = 4'h5;
	localparam logic [3:0]  LAST_SLOT      = 4'hc;
	localparam logic [4:0]  TAG_LAST_BIT   = 5'h0f;
	localparam logic [4:0]  SLOT_LAST_BIT  = 5'h13;
	localparam logic [2:0]  SLOT_RESERVED  = 3'h7;
	localparam int SAMPLE_LSB = 8;
	localparam int TAG_FRAME  = 15;
	localparam int TAG_ADDR   = 14;
	localparam int TAG_DATA   = 13;
	localparam int CMD_RD_BIT = 19;
	localparam int CMD_A_LSB  = 12;
	localparam int CMD_D_LSB  = 4;
	// Gain decode in half-dB units
	localparam int MIX_GAIN_TOP  = 12;
	localparam int MIX_GAIN_STEP = 6;
	localparam int VOL_STEP      = 3;
	localparam logic [6:0]  VOL_FLOOR = 7'h5d;
	// Bit clock half period in system clock cycles
	localparam int BITCLK_HALF = 8;
	// Zero-cross timeout in system clock cycles
	localparam int ZC_TIMEOUT  = 4096;
	typedef enum logic [1:0] {
		EAR_INV_HPR   = 2'b00,
		EAR_MIDRAIL   = 2'b01,
		EAR_HP_MONO   = 2'b10,
		EAR_INV_PHONE = 2'b11
	} axgc_ear_src_t;
endpackage

// File: src/axgc_vol_if.sv
// Interface between the register bank and one volume applier
`timescale 1ns/1ps
`default_nettype none
interface axgc_vol_if;
	logic [5:0] target;
	logic       zcEn;
	logic       crossing;
	logic [5:0] applied;
	logic       pending;
	modport ctrl (output target, zcEn, crossing, input applied, pending);
	modport vol (input target, zcEn, crossing, output applied, pending);
endinterface
`default_nettype wire

// File: src/axgc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module axgc_sync #(
	parameter int W = 1
) (
	input  wire logic [W-1:0] pinIn,  // Asynchronous pins
	input  wire logic         clk,    // System clock
	input  wire logic         rst,    // Async reset
	output var  logic [W-1:0] pinOut  // Filtered level
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// Change counts only once stages two and three agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q   <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
			pinOut <= '0;
		end else begin
			s1_q   <= pinIn;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			pinOut <= (pinOut & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
		end
	end
endmodule
`default_nettype wire

// File: src/axgc_zc_vol.sv
// Volume applier that can wait for a zero crossing or a timeout
`timescale 1ns/1ps
`default_nettype none
module axgc_zc_vol #(
	parameter int TIMEOUT = axgc_pkg::ZC_TIMEOUT
) (
	input  wire logic  clk,  // System clock
	input  wire logic  rst,  // Async reset
	axgc_vol_if.vol    bus   // Target in, applied code out
);
	localparam int CW = $clog2(TIMEOUT + 1);
	localparam logic [CW-1:0] LAST = CW'(TIMEOUT - 1);
	logic [CW-1:0] wait_q;

	// Apply at once, or on crossing, or when the wait runs out
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus.applied <= '0;
			bus.pending <= 1'b0;
			wait_q      <= '0;
		end else if (bus.target == bus.applied) begin
			bus.pending <= 1'b0;
			wait_q      <= '0;
		end else if (!bus.zcEn || bus.crossing || wait_q == LAST) begin
			bus.applied <= bus.target;
			bus.pending <= 1'b0;
			wait_q      <= '0;
		end else begin
			bus.pending <= 1'b1;
			wait_q      <= wait_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: src/axgc_top.sv
// Aux converter source select and output gain register bank on the link
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Operation
// - The source bit picks the register DC value when clear, the slot sample when set.
// - Slot samples are offset binary and pass as is; DC values get no offset.
// - Slot codes 0 to 6 take bits 19:8 of slots 5 to 11; code 7 is never to be used.
// - The 12-bit DC value runs 000h minimum to FFFh full scale and resets to zero.
// - Slot samples are taken whenever the frame tags them valid, at any rate.
// - The enable bit powers the converter when set and resets cleared.
// - The aux-to-headphone-mixer mute bit mutes when set and resets set.
// - Each 3-bit aux mixer gain is +6dB at 000 falling 3dB per code, reset 010.
// - The aux-to-speaker-mixer mute is bit 11, reset set, gain at bits 10:8.
// - The aux-to-phone-mixer mute is bit 7, reset set, gain at bits 6:4.
// - One headphone mute bit silences both outputs and resets set.
// - Headphone volumes lose 1.5dB per code to -46.5dB, top bit set gives -46.5dB.
// - With zero-cross clear a volume applies at once, else at a crossing or timeout.
// - Ear source 00 inverted right, 01 midrail, 10 headphone mono, 11 inverted phone.
module axgc_top #(
	parameter int BITCLK_HALF = axgc_pkg::BITCLK_HALF,
	parameter int ZC_TIMEOUT  = axgc_pkg::ZC_TIMEOUT
) (
	input  wire logic        clk,           // System clock, 200 MHz
	input  wire logic        rst,           // Async reset, active high
	input  wire logic        linkSyncPin,   // Frame sync from controller
	input  wire logic        linkDataPin,   // Serial data from controller
	input  wire logic [2:0]  zeroCrossPin,  // Crossing toggles: ear, right, left
	output var  logic        linkBitClk,    // Bit clock to controller
	output var  logic        linkRespData,  // Serial data to controller
	output var  logic [11:0] convCode,      // Converter input code
	output var  logic        convStrobe,    // New slot sample pulse
	output var  logic        convEnable,    // Converter powered
	output var  logic        hpMixMute,     // Aux to headphone mixer mute
	output var  logic [5:0]  hpMixGain,     // Signed half-dB
	output var  logic        spkMixMute,    // Aux to speaker mixer mute
	output var  logic [5:0]  spkMixGain,    // Signed half-dB
	output var  logic        phMixMute,     // Aux to phone mixer mute
	output var  logic [5:0]  phMixGain,     // Signed half-dB
	output var  logic        hpMute,        // Both headphone outputs muted
	output var  logic [6:0]  hpLeftAtten,   // Half-dB attenuation
	output var  logic [6:0]  hpRightAtten,  // Half-dB attenuation
	output var  logic        earMute,       // Ear buffer off
	output var  logic [1:0]  earSource,     // Ear source select
	output var  logic        earInvert,     // Ear output inverted
	output var  logic [6:0]  earAtten       // Half-dB attenuation
);
	localparam int DW = $clog2(BITCLK_HALF);
	localparam logic [DW-1:0] HALF_LAST = DW'(BITCLK_HALF - 1);

	// 3-bit mixer gain code to signed half-dB
	function automatic logic [5:0] mixGain(input logic [2:0] code);
		return 6'(axgc_pkg::MIX_GAIN_TOP - int'(code) * axgc_pkg::MIX_GAIN_STEP);
	endfunction

	// 6-bit volume code to half-dB attenuation
	function automatic logic [6:0] volAtten(input logic [5:0] code);
		if (code[5]) begin
			return axgc_pkg::VOL_FLOOR;
		end
		return 7'(int'(code[4:0]) * axgc_pkg::VOL_STEP);
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Pins and bit clock

	logic [4:0]    pinS;
	logic [2:0]    zcPrev_q;
	logic [DW-1:0] div_q;
	logic          riseEvt;
	logic          fallEvt;
	logic          linkSync;
	logic          linkData;

	axgc_sync #(.W(5)) uSync (
		.pinIn  ({zeroCrossPin, linkDataPin, linkSyncPin}),
		.clk    (clk),
		.rst    (rst),
		.pinOut (pinS)
	);
	assign linkSync = pinS[0];
	assign linkData = pinS[1];

	// Divider sets the bit period; needs a half period above the sync delay
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_q      <= '0;
			linkBitClk <= 1'b0;
		end else if (div_q == HALF_LAST) begin
			div_q      <= '0;
			linkBitClk <= ~linkBitClk;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end
	assign riseEvt = (div_q == HALF_LAST) && !linkBitClk;
	assign fallEvt = (div_q == HALF_LAST) && linkBitClk;

	//////////////////////////////////////////////////////////////////////////
	// Frame receive

	logic [3:0]  slot_q;
	logic [4:0]  left_q;
	logic [19:0] sh_q;
	logic        syncPrev_q;
	logic        isStart;
	logic [3:0]  curSlot;
	logic [4:0]  curLeft;
	logic [19:0] word;
	logic        wordDone;

	assign isStart  = linkSync && !syncPrev_q;
	assign curSlot  = isStart ? 4'h0 : slot_q;
	assign curLeft  = isStart ? axgc_pkg::TAG_LAST_BIT : left_q;
	assign word     = {sh_q[18:0], linkData};
	assign wordDone = fallEvt && (curLeft == 5'h00);

	// Sample on the falling edge; a sync rise realigns to the tag slot
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			slot_q     <= 4'h0;
			left_q     <= axgc_pkg::TAG_LAST_BIT;
			sh_q       <= '0;
			syncPrev_q <= 1'b0;
		end else if (fallEvt) begin
			sh_q       <= word;
			syncPrev_q <= linkSync;
			if (curLeft != 5'h00) begin
				slot_q <= curSlot;
				left_q <= curLeft - 1'b1;
			end else if (curSlot == axgc_pkg::LAST_SLOT) begin
				slot_q <= 4'h0;
				left_q <= axgc_pkg::TAG_LAST_BIT;
			end else begin
				slot_q <= curSlot + 1'b1;
				left_q <= axgc_pkg::SLOT_LAST_BIT;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Commands

	logic [15:0] tag_q;
	logic [19:0] cmd_q;
	logic        cmdOk;
	logic        wrEn;
	logic        rdEn;
	logic [6:0]  cmdAddr;
	logic [15:0] wrData;
	logic        rdPend_q;
	logic [6:0]  rdIdx_q;
	logic        respValid_q;
	logic [6:0]  respIdx_q;
	logic [15:0] respData_q;
	logic [15:0] hpVol_q;
	logic [15:0] auxOut_q;
	logic [15:0] ear_q;
	logic [15:0] auxIn_q;

	assign cmdOk   = wordDone && curSlot == axgc_pkg::CMD_DATA_SLOT
		&& tag_q[axgc_pkg::TAG_FRAME] && tag_q[axgc_pkg::TAG_ADDR];
	assign rdEn    = cmdOk && cmd_q[axgc_pkg::CMD_RD_BIT];
	assign wrEn    = cmdOk && !cmd_q[axgc_pkg::CMD_RD_BIT] && tag_q[axgc_pkg::TAG_DATA];
	assign cmdAddr = cmd_q[axgc_pkg::CMD_A_LSB +: 7];
	assign wrData  = word[axgc_pkg::CMD_D_LSB +: 16];

	// Readback; unmapped indices answer zero
	function automatic logic [15:0] readReg(input logic [6:0] idx);
		case (idx)
			axgc_pkg::HP_VOL_ADDR:   return hpVol_q;
			axgc_pkg::AUX_OUT_ADDR:  return auxOut_q;
			axgc_pkg::EAR_CTRL_ADDR: return ear_q;
			axgc_pkg::AUX_IN_ADDR:   return auxIn_q;
			default:                 return 16'h0000;
		endcase
	endfunction

	// Tag and address slots; a read is answered in the next frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tag_q       <= '0;
			cmd_q       <= '0;
			rdPend_q    <= 1'b0;
			rdIdx_q     <= '0;
			respValid_q <= 1'b0;
			respIdx_q   <= '0;
			respData_q  <= '0;
		end else if (wordDone) begin
			if (curSlot == 4'h0) begin
				tag_q <= word[15:0];
			end
			if (curSlot == axgc_pkg::CMD_ADDR_SLOT) begin
				cmd_q <= word;
			end
			if (rdEn) begin
				rdPend_q <= 1'b1;
				rdIdx_q  <= cmdAddr;
			end
			if (curSlot == axgc_pkg::LAST_SLOT) begin
				respValid_q <= rdPend_q;
				respIdx_q   <= rdIdx_q;
				respData_q  <= readReg(rdIdx_q);
				rdPend_q    <= 1'b0;
			end
		end
	end

	// Register bank, reserved bits held at zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hpVol_q  <= axgc_pkg::HP_VOL_RST;
			auxOut_q <= axgc_pkg::AUX_OUT_RST;
			ear_q    <= axgc_pkg::EAR_RST;
			auxIn_q  <= axgc_pkg::AUX_IN_RST;
		end else if (wrEn) begin
			case (cmdAddr)
				axgc_pkg::HP_VOL_ADDR:   hpVol_q  <= wrData & axgc_pkg::HP_VOL_MASK;
				axgc_pkg::AUX_OUT_ADDR:  auxOut_q <= wrData & axgc_pkg::AUX_OUT_MASK;
				axgc_pkg::EAR_CTRL_ADDR: ear_q    <= wrData & axgc_pkg::EAR_MASK;
				axgc_pkg::AUX_IN_ADDR:   auxIn_q  <= wrData & axgc_pkg::AUX_IN_MASK;
				default: ;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Response transmit

	logic [19:0] txWord;

	// Bits go out on the rising edge for the controller's falling edge
	always_comb begin
		txWord = '0;
		case (slot_q)
			4'h0: begin
				txWord[axgc_pkg::TAG_FRAME] = 1'b1;
				txWord[axgc_pkg::TAG_ADDR]  = respValid_q;
				txWord[axgc_pkg::TAG_DATA]  = respValid_q;
			end
			axgc_pkg::CMD_ADDR_SLOT: begin
				txWord[axgc_pkg::CMD_A_LSB +: 7] = respValid_q ? respIdx_q : 7'h00;
			end
			axgc_pkg::CMD_DATA_SLOT: begin
				txWord[axgc_pkg::CMD_D_LSB +: 16] = respValid_q ? respData_q : 16'h0000;
			end
			default: txWord = '0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			linkRespData <= 1'b0;
		end else if (riseEvt) begin
			linkRespData <= txWord[left_q];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Converter source

	logic       srcSlot;
	logic [2:0] slotSel;
	logic [3:0] tagIdx;
	logic       take;

	assign srcSlot = auxIn_q[axgc_pkg::SRCSEL_BIT];
	assign slotSel = auxIn_q[axgc_pkg::SLOT_LSB +: 3];
	assign tagIdx  = 4'(axgc_pkg::TAG_FRAME) - curSlot;
	// Reserved slot code never matches, so nothing is taken
	assign take    = wordDone && srcSlot && slotSel != axgc_pkg::SLOT_RESERVED
		&& curSlot == axgc_pkg::FIRST_AUX_SLOT + {1'b0, slotSel}
		&& tag_q[axgc_pkg::TAG_FRAME] && tag_q[tagIdx];

	// Slot sample is offset binary already, so it is passed unaltered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			convCode   <= '0;
			convStrobe <= 1'b0;
		end else begin
			convStrobe <= take;
			if (!srcSlot) begin
				convCode <= auxIn_q[axgc_pkg::DC_LSB +: 12];
			end else if (take) begin
				convCode <= word[axgc_pkg::SAMPLE_LSB +: 12];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Mixer paths and ear output

	// Mutes act at once; they are not held for crossings
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			convEnable <= 1'b0;
			hpMixMute  <= 1'b1;
			spkMixMute <= 1'b1;
			phMixMute  <= 1'b1;
			hpMixGain  <= '0;
			spkMixGain <= '0;
			phMixGain  <= '0;
		end else begin
			convEnable <= auxOut_q[axgc_pkg::ENABLE_BIT];
			hpMixMute  <= auxOut_q[axgc_pkg::MUTE_BIT];
			spkMixMute <= auxOut_q[axgc_pkg::SPK_MUTE_BIT];
			phMixMute  <= auxOut_q[axgc_pkg::PH_MUTE_BIT];
			hpMixGain  <= mixGain(auxOut_q[axgc_pkg::HPG_LSB +: 3]);
			spkMixGain <= mixGain(auxOut_q[axgc_pkg::SPKG_LSB +: 3]);
			phMixGain  <= mixGain(auxOut_q[axgc_pkg::PHG_LSB +: 3]);
		end
	end

	// Inverting sources flag the ear buffer to invert
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hpMute    <= 1'b1;
			earMute   <= 1'b1;
			earSource <= axgc_pkg::EAR_INV_HPR;
			earInvert <= 1'b1;
		end else begin
			hpMute    <= hpVol_q[axgc_pkg::MUTE_BIT];
			earMute   <= ear_q[axgc_pkg::MUTE_BIT];
			earSource <= ear_q[axgc_pkg::EARSRC_LSB +: 2];
			earInvert <= ear_q[axgc_pkg::EARSRC_LSB +: 2] == axgc_pkg::EAR_INV_HPR
				|| ear_q[axgc_pkg::EARSRC_LSB +: 2] == axgc_pkg::EAR_INV_PHONE;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Volumes: left, right, ear

	axgc_vol_if volIf [3] ();
	logic [5:0] volTarget [3];
	logic       volZc [3];

	assign volTarget[0] = hpVol_q[axgc_pkg::LVOL_LSB +: 6];
	assign volTarget[1] = hpVol_q[axgc_pkg::RVOL_LSB +: 6];
	assign volTarget[2] = ear_q[axgc_pkg::RVOL_LSB +: 6];
	assign volZc[0]     = hpVol_q[axgc_pkg::ZC_BIT];
	assign volZc[1]     = hpVol_q[axgc_pkg::ZC_BIT];
	assign volZc[2]     = ear_q[axgc_pkg::ZC_BIT];

	// Crossing comparator toggles its pin at each crossing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			zcPrev_q <= '0;
		end else begin
			zcPrev_q <= pinS[4:2];
		end
	end

	for (genvar i = 0; i < 3; i++) begin : gVol
		assign volIf[i].target   = volTarget[i];
		assign volIf[i].zcEn     = volZc[i];
		assign volIf[i].crossing = pinS[2 + i] ^ zcPrev_q[i];
		axgc_zc_vol #(.TIMEOUT(ZC_TIMEOUT)) uVol (
			.clk (clk),
			.rst (rst),
			.bus (volIf[i])
		);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hpLeftAtten  <= '0;
			hpRightAtten <= '0;
			earAtten     <= '0;
		end else begin
			hpLeftAtten  <= volAtten(volIf[0].applied);
			hpRightAtten <= volAtten(volIf[1].applied);
			earAtten     <= volAtten(volIf[2].applied);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	src_dc_a: assert property (!srcSlot ##1 !srcSlot |-> convCode == $past(auxIn_q[11:0]))
		else $error("DC source not driving converter");
	offset_pass_a: assert property (take |=> convStrobe && convCode == $past(word[19:8]))
		else $error("slot sample altered");
	slot_map_a: assert property (convStrobe |->
		$past(curSlot) == axgc_pkg::FIRST_AUX_SLOT + {1'b0, $past(slotSel)})
		else $error("sample from wrong slot");
	rate_one_a: assert property (convStrobe |=> !convStrobe [*8])
		else $error("more than one sample per frame");
	dc_full_a: assert property (!srcSlot && auxIn_q[11:0] == 12'hfff |=> convCode == 12'hfff)
		else $error("full scale DC lost");
	enable_rise_a: assert property ($rose(auxOut_q[0]) |=> convEnable ##1 convEnable)
		else $error("enable did not follow");
	hp_path_mute_a: assert property (wrEn && cmdAddr == axgc_pkg::AUX_OUT_ADDR |=> ##1
		hpMixMute == $past(wrData[15], 2))
		else $error("headphone mixer mute wrong");
	mix_gain_a: assert property (##1 $signed(hpMixGain) == 6'(12 - 6 * int'($past(auxOut_q[14:12]))))
		else $error("mixer gain decode wrong");
	spk_path_a: assert property (wrEn && cmdAddr == axgc_pkg::AUX_OUT_ADDR |=> ##1
		spkMixMute == $past(wrData[11], 2) && phMixMute == $past(wrData[7], 2))
		else $error("speaker or phone mute wrong");
	phone_gain_a: assert property (auxOut_q[6:4] == 3'h7 |=> $signed(phMixGain) == -6'sd30)
		else $error("phone gain floor wrong");
	hp_mute_a: assert property ($fell(hpVol_q[15]) |=> !hpMute)
		else $error("headphone unmute late");
	vol_floor_a: assert property (volIf[0].applied[5] |=> hpLeftAtten == 7'h5d)
		else $error("volume floor wrong");
	zc_off_a: assert property (!volIf[1].zcEn && volIf[1].target != volIf[1].applied
		|=> volIf[1].applied == $past(volIf[1].target))
		else $error("volume not immediate");
	zc_hold_a: assert property (volIf[0].zcEn && volIf[0].pending && !volIf[0].crossing
		&& volIf[0].target != volIf[0].applied && gVol[0].uVol.wait_q != ZC_TIMEOUT - 1
		|=> $stable(volIf[0].applied))
		else $error("volume changed early");
	ear_inv_a: assert property (ear_q[10:9] == 2'b01 ##1 ear_q[10:9] == 2'b01 |-> !earInvert)
		else $error("midrail inverted");
	ear_mute_a: assert property ($rose(ear_q[15]) |=> earMute)
		else $error("ear mute late");

	cover property (wrEn);
	cover property (respValid_q && riseEvt);
	cover property (convStrobe);
	cover property (volIf[0].pending ##1 !volIf[0].pending);
endmodule
`default_nettype wire

// File: dv/axgc_link_host.sv
// Behavioural link controller that frames commands and slot samples
`timescale 1ns/1ps
`default_nettype none
module axgc_link_host (
	input  wire logic         bitClk,     // Bit clock from the block
	input  wire logic         respData,   // Serial response
	input  wire logic [1:0]   cmdKind,    // 0 idle, 1 write, 2 read
	input  wire logic [6:0]   cmdAddr,    // Register index
	input  wire logic [15:0]  cmdData,    // Write data
	input  wire logic         sampleOn,   // Slots 5 to 11 tagged valid
	input  wire logic [11:0]  sampleVal,  // Base sample, slot number mixed in
	output var  logic         syncPin,    // Frame sync
	output var  logic         dataPin,    // Serial data
	output var  logic [7:0]   frameCnt,   // Frames started
	output var  logic [255:0] respFrame   // Last whole response frame
);
	logic [255:0] nextFrame;
	logic [255:0] txQ = '0;
	logic [255:0] rxQ = '0;
	logic [7:0]   bitIdx = 8'h00;
	logic         syncSeen = 1'b0;
	initial begin
		syncPin = 1'b0;
		dataPin = 1'b0;
		frameCnt = 8'h00;
		respFrame = '0;
	end
	//////////////////////////////////////////////////////////////////////////
	// Untagged slots still carry data so the tag gating is exercised
	always_comb begin
		nextFrame = '0;
		nextFrame[255] = 1'b1;
		nextFrame[254] = cmdKind != 2'd0;
		nextFrame[253] = cmdKind == 2'd1;
		nextFrame[239] = cmdKind == 2'd2;
		nextFrame[238:232] = cmdAddr;
		nextFrame[219:204] = cmdData;
		for (int s = 5; s < 12; s++) begin
			nextFrame[255 - s] = sampleOn;
			nextFrame[248 - 20 * s +: 12] = sampleVal ^ 12'(s);
		end
	end
	// Frame latched whole at its first bit, MSB first
	always @(posedge bitClk) begin
		syncPin <= bitIdx < 8'd16;
		dataPin <= bitIdx == 8'd0 ? nextFrame[255] : txQ[255];
		txQ <= bitIdx == 8'd0 ? nextFrame << 1 : txQ << 1;
		frameCnt <= frameCnt + 8'(bitIdx == 8'd0);
		bitIdx <= bitIdx + 8'd1;
	end
	// Response bits share our bit slots; the whole last frame is kept at the next start
	always @(negedge bitClk) begin
		rxQ <= {rxQ[254:0], respData};
		syncSeen <= syncPin;
		if (syncPin && !syncSeen)
			respFrame <= rxQ;
	end
endmodule
`default_nettype wire

// File: dv/axgc_top_tb_top.sv
// Self-checking bench for the aux converter and output gain block
`timescale 1ns/1ps
`default_nettype none
module axgc_top_tb_top;
	logic clk, rst, linkSyncPin, linkDataPin, linkBitClk, linkRespData, convStrobe, convEnable;
	logic hpMixMute, spkMixMute, phMixMute, hpMute, earMute, earInvert, sampleOn;
	logic [2:0]   zeroCrossPin;
	logic [11:0]  convCode, sampleVal;
	logic [5:0]   hpMixGain, spkMixGain, phMixGain;
	logic [6:0]   hpLeftAtten, hpRightAtten, earAtten, cmdAddr;
	logic [1:0]   earSource, cmdKind;
	logic [15:0]  cmdData;
	logic [7:0]   frameCnt;
	logic [255:0] respFrame;
	int           n_fail, compares, strobeCnt = 0;
	axgc_top #(.BITCLK_HALF(6), .ZC_TIMEOUT(4000)) dut_u (.clk(clk), .rst(rst),
		.linkSyncPin(linkSyncPin), .linkDataPin(linkDataPin), .zeroCrossPin(zeroCrossPin),
		.linkBitClk(linkBitClk), .linkRespData(linkRespData), .convCode(convCode),
		.convStrobe(convStrobe), .convEnable(convEnable), .hpMixMute(hpMixMute),
		.hpMixGain(hpMixGain), .spkMixMute(spkMixMute), .spkMixGain(spkMixGain),
		.phMixMute(phMixMute), .phMixGain(phMixGain), .hpMute(hpMute),
		.hpLeftAtten(hpLeftAtten), .hpRightAtten(hpRightAtten), .earMute(earMute),
		.earSource(earSource), .earInvert(earInvert), .earAtten(earAtten));
	axgc_link_host host_u (.bitClk(linkBitClk), .respData(linkRespData), .cmdKind(cmdKind),
		.cmdAddr(cmdAddr), .cmdData(cmdData), .sampleOn(sampleOn), .sampleVal(sampleVal),
		.syncPin(linkSyncPin), .dataPin(linkDataPin), .frameCnt(frameCnt),
		.respFrame(respFrame));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) if (convStrobe === 1'b1) strobeCnt <= strobeCnt + 1;
	//////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// Bounded wait for the next frame start; a hang ends the run
	task automatic wait_frame();
		logic [7:0] start;
		start = frameCnt;
		for (int i = 0; i < 4000 && frameCnt === start; i++)
			@(negedge clk);
		if (frameCnt === start) begin
			check("frame tick", 1'b0, 1'b1);
			finish_test();
		end
	endtask
	// Command stays up until the frame that carries it has begun
	task automatic issue(input logic [1:0] k, input logic [6:0] a, input logic [15:0] d,
		input logic s);
		@(negedge clk);
		cmdKind = k;
		cmdAddr = a;
		cmdData = d;
		sampleOn = s;
		wait_frame();
	endtask
	function automatic logic [5:0] mg(input logic [2:0] c);
		return 6'(12 - 6 * int'(c));
	endfunction
	//////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check("reset mix", {convCode, convStrobe, convEnable, hpMixMute, hpMixGain, spkMixMute,
			spkMixGain, phMixMute, phMixGain}, {14'h0, 1'b1, 6'h0, 1'b1, 6'h0, 1'b1, 6'h0});
		check("reset out", {hpMute, hpLeftAtten, hpRightAtten, earMute, earSource, earInvert,
			earAtten}, {1'b1, 14'h0, 1'b1, 2'b00, 1'b1, 7'h00});
		issue(2'd2, axgc_pkg::AUX_OUT_ADDR, 16'h0000, 1'b0);
		issue(2'd0, 7'h00, 16'h0000, 1'b0);
		wait_frame();
		repeat (20) @(negedge clk);
		check("read aux out", {respFrame[254:253], respFrame[238:232], respFrame[219:204]},
			{2'b11, 7'h12, 16'haaa0});
	endtask
	// Back-to-back writes; each frame is judged once the next has begun
	task automatic t_gains();
		logic [63:0] exp;
		logic [15:0] v;
		exp = '0;
		for (int k = 0; k < 5; k++) begin
			v = {k[0], 3'(2 * k), !k[0], 3'(2 * k + 1), k[1], 3'(7 - 2 * k), 3'h0, k[0] ^ k[1]};
			issue(k < 4 ? 2'd1 : 2'd0, axgc_pkg::AUX_OUT_ADDR, v, 1'b0);
			if (k > 0)
				check("aux out", {convEnable, hpMixMute, hpMixGain, spkMixMute, spkMixGain,
					phMixMute, phMixGain}, exp);
			exp = {v[0], v[15], mg(v[14:12]), v[11], mg(v[10:8]), v[7], mg(v[6:4])};
		end
	endtask
	// Every slot code, then the reserved code, then an untagged frame
	task automatic t_slots();
		int snap;
		logic [11:0] exp;
		snap = strobeCnt;
		exp = 12'h000;
		for (int c = 0; c < 10; c++) begin
			issue(c < 9 ? 2'd1 : 2'd0, axgc_pkg::AUX_IN_ADDR, {1'b1, c < 8 ? 3'(c) : 3'h0, 12'h0},
				c < 8);
			if (c > 0 && c < 8)
				exp = sampleVal ^ 12'(c + 4);
			if (c > 0)
				check("slot code", convCode, exp);
			if (c > 0)
				check("slot strobes", strobeCnt - snap, c < 8);
			snap = strobeCnt;
		end
	endtask
	task automatic t_dc();
		issue(2'd1, axgc_pkg::AUX_IN_ADDR, 16'h0fff, 1'b1);
		issue(2'd0, 7'h00, 16'h0000, 1'b0);
		check("dc code", convCode, 12'hfff);
	endtask
	// Zero-cross off, then on with a crossing on the left and a timeout on the right
	task automatic t_volume();
		issue(2'd1, axgc_pkg::HP_VOL_ADDR, 16'h2005, 1'b0);
		issue(2'd0, 7'h00, 16'h0000, 1'b0);
		check("hp now", {hpMute, hpLeftAtten, hpRightAtten}, {1'b0, 7'd93, 7'd15});
		issue(2'd1, axgc_pkg::HP_VOL_ADDR, 16'h819e, 1'b0);
		issue(2'd0, 7'h00, 16'h0000, 1'b0);
		check("hp held", {hpMute, hpLeftAtten, hpRightAtten}, {1'b1, 7'd93, 7'd15});
		zeroCrossPin[0] = ~zeroCrossPin[0];
		repeat (10) @(negedge clk);
		check("hp cross", {hpLeftAtten, hpRightAtten}, {7'd3, 7'd15});
		repeat (2000) @(negedge clk);
		check("hp timeout", hpRightAtten, 7'd90);
	endtask
	// Mute, source and volume set together in each write, every source code
	task automatic t_ear();
		logic [63:0] exp;
		logic [15:0] v;
		exp = '0;
		for (int s = 0; s < 5; s++) begin
			v = {s[0], 4'h0, 2'(s), 3'h0, 6'(13 * s)};
			issue(s < 4 ? 2'd1 : 2'd0, axgc_pkg::EAR_CTRL_ADDR, v, 1'b0);
			if (s > 0)
				check("ear", {earMute, earSource, earInvert, earAtten}, exp);
			exp = {v[15], v[10:9], v[10:9] == 2'b00 || v[10:9] == 2'b11,
				v[5] ? 7'd93 : 7'(3 * v[4:0])};
		end
	endtask
	//////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		zeroCrossPin = 3'h0;
		cmdKind = 2'd0;
		cmdAddr = 7'h00;
		cmdData = 16'h0000;
		sampleOn = 1'b0;
		sampleVal = 12'h5a3;
		n_fail = 0;
		compares = 0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_gains();
		t_slots();
		t_dc();
		t_volume();
		t_ear();
		finish_test();
	end
endmodule
`default_nettype wire
